// >>> verilog/rsq_pkg.sv
package rsq_pkg;
  // Clock and timing
  localparam int unsigned CLK_NS       = 20;
  localparam int unsigned POR_EXT_NS   = 30000;
  localparam int unsigned POR_EXT_CYC  =
    (POR_EXT_NS / CLK_NS < 1) ? 1 : POR_EXT_NS / CLK_NS;
  localparam int unsigned BOR_EXT_NS   = 100000;
  localparam int unsigned BOR_EXT_CYC  =
    (BOR_EXT_NS / CLK_NS < 1) ? 1 : BOR_EXT_NS / CLK_NS;
  localparam int unsigned CLKMON_NS    = 900000;
  localparam int unsigned CLKMON_CYC   =
    (CLKMON_NS / CLK_NS < 1) ? 1 : CLKMON_NS / CLK_NS;
  localparam int unsigned POWER_UP_TIMER_UNIT_NS = 1000000;
  localparam int unsigned POWER_UP_TIMER_UNIT_CYC = POWER_UP_TIMER_UNIT_NS / CLK_NS;
  localparam int unsigned PIN_FILT_CYC = 4;

  // Register map
  localparam logic [3:0] ADR_FLAGS = 4'h0;
  localparam logic [3:0] ADR_CTRL  = 4'h4;
  localparam logic [3:0] ADR_STAT  = 4'h8;

  // Cause flag positions
  localparam int unsigned FLG_POR  = 0;
  localparam int unsigned FLG_BOR  = 1;
  localparam int unsigned FLG_WDT  = 4;
  localparam int unsigned FLG_SW   = 6;
  localparam int unsigned FLG_PIN  = 7;
  localparam int unsigned FLG_CM   = 9;
  localparam int unsigned FLG_ILL  = 14;
  localparam int unsigned FLG_TRAP = 15;
  localparam logic [15:0] FLAG_MASK    = 16'hc2d3;
  localparam logic [15:0] FLAG_POR_VAL = 16'h0003;
  localparam logic [15:0] FLAG_BOR_KEEP = 16'h0083;

  // Control fields
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_MON_EN  = 3;
  localparam logic [3:0]  CTRL_RST     = 4'h7;

  localparam logic [23:0] RESET_VECTOR  = 24'h000000;
  localparam logic [3:0]  TRAP_HARD_MIN = 4'hd;
  localparam logic [7:0]  ILLEGAL_UPPER = 8'h3f;

  typedef enum logic [5:0] {
    ST_POR  = 6'h01,
    ST_BOR  = 6'h02,
    ST_POWER_UP_TIMER = 6'h04,
    ST_OSC  = 6'h08,
    ST_RUN  = 6'h10,
    ST_WARM = 6'h20
  } rsq_state_t;

  typedef struct packed {
    logic pin;
    logic sw;
    logic wdt;
    logic trap;
    logic cm;
    logic ill;
  } rsq_warm_t;
endpackage

// >>> verilog/rsq_top.sv
// Function
// - Hold reset until supply passes power-on threshold plus extension time.
// - Power-on reset sets the power-on cause flag, bit 0.
// - Supply below brown-out threshold resets until restored plus extension.
// - Brown-out reset sets the brown-out cause flag, bit 1.
// - Power-up timer extends reset after brown-out, then oscillator starts.
// - Three-bit select picks one of eight power-up delays, zero to 128 ms.
// - Brown-out extension and power-up delay restart on each supply recovery.
// - With clock ready, execution starts at program address zero.
// - Enabled clock monitor starts only after clock ready plus monitor delay.
// - Filter short pin glitches; valid low pulses reset and set pin flag.
// - Reset instruction resets one cycle, keeps clock source, then fetches.
// - Software reset sets the software cause flag, bit 6.
// - Watchdog time-out in run mode resets, clock source unchanged.
// - Watchdog time-out in sleep or idle only wakes the processor.
// - Watchdog time-out sets the watchdog cause flag, bit 4.
// - Lower-priority hard trap during higher trap service resets device.
// - Trap conflict reset sets the trap cause flag, bit 15.
// - Shadow copies compare pin mapping registers; difference causes reset.
// - Mismatch sets flag bit 9; absent entirely on variants without it.
// - Illegal opcode, uninitialised pointer, security fault set bit 14.
// - Executing an opcode with upper byte 3Fh resets the device.
// - Cold reset loads configured oscillator; other resets keep current one.
// - Software may set or clear all flags without causing a reset.
//
// The register addresses and register access over Wishbone were left to the implementer.
module rsq_top #(
  parameter int unsigned BOR_EXT_CYC   = rsq_pkg::BOR_EXT_CYC,
  parameter int unsigned CLKMON_CYC    = rsq_pkg::CLKMON_CYC,
  parameter int unsigned POWER_UP_TIMER_UNIT_CYC = rsq_pkg::POWER_UP_TIMER_UNIT_CYC,
  parameter int unsigned PIN_FILT_CYC  = rsq_pkg::PIN_FILT_CYC,
  parameter int unsigned MAP_W         = 16,
  parameter bit          HAS_CM        = 1'b1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             power_on_threshold_i,
  input  wire logic             brown_out_threshold_i,
  input  wire logic             external_reset_pin_n_i,
  input  wire logic             osc_ready_i,
  input  wire logic             sw_reset_i,
  input  wire logic             wdt_timeout_i,
  input  wire logic             wdt_clear_i,
  input  wire logic             sleep_mode_i,
  input  wire logic             hard_trap_i,
  input  wire logic [3:0]       hard_trap_level_i,
  input  wire logic             trap_active_i,
  input  wire logic [3:0]       trap_active_level_i,
  input  wire logic [MAP_W-1:0] pin_map_i,
  input  wire logic [MAP_W-1:0] pin_map_wdata_i,
  input  wire logic             pin_map_we_i,
  input  wire logic             opcode_valid_i,
  input  wire logic [7:0]       opcode_upper_i,
  input  wire logic             uninit_w_i,
  input  wire logic             security_i,
  input  wire logic [2:0]       initial_oscillator_select_i,
  input  wire logic [2:0]       current_oscillator_select_i,
  output logic                  system_reset_o,
  output logic                  fetch_start_o,
  output logic      [23:0]      fetch_addr_o,
  output logic      [2:0]       clock_source_o,
  output logic                  clock_monitor_o,
  output logic                  wake_o
);

  rsq_pkg::rsq_state_t state;
  rsq_pkg::rsq_state_t next_state;
  rsq_pkg::rsq_warm_t  warm;
  logic [31:0]      cnt;
  logic [31:0]      next_cnt;
  logic [31:0]      mon_cnt;
  logic [15:0]      flags;
  logic [15:0]      next_flags;
  logic [3:0]       ctrl;
  logic [MAP_W-1:0] shadow;
  logic [7:0]       pin_cnt;
  logic             pin_low_f;
  logic             por_m, por_s, bor_m, bor_s;
  logic             pin_m, pin_s, osc_m, osc_s;

  // Two-stage synchronisers for analog and pin levels
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      por_m <= 1'b0;
      por_s <= 1'b0;
      bor_m <= 1'b0;
      bor_s <= 1'b0;
      pin_m <= 1'b1;
      pin_s <= 1'b1;
      osc_m <= 1'b0;
      osc_s <= 1'b0;
    end
    else if (ce_i)
    begin
      por_m <= power_on_threshold_i;
      por_s <= por_m;
      bor_m <= brown_out_threshold_i;
      bor_s <= bor_m;
      pin_m <= external_reset_pin_n_i;
      pin_s <= pin_m;
      osc_m <= osc_ready_i;
      osc_s <= osc_m;
    end
  end

  // Pin glitch filter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_cnt   <= 8'h00;
      pin_low_f <= 1'b0;
    end
    else if (ce_i)
    begin
      if (pin_s)
      begin
        pin_cnt   <= 8'h00;
        pin_low_f <= 1'b0;
      end
      else if (32'(pin_cnt) + 32'd1 >= PIN_FILT_CYC)
        pin_low_f <= 1'b1;
      else
        pin_cnt <= pin_cnt + 8'h01;
    end
  end

  // Shadow copy of the pin mapping registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      shadow <= '0;
    else if (ce_i && pin_map_we_i)
      shadow <= pin_map_wdata_i;
  end

  // Source decoding
  wire cold_por = !por_s;
  wire cold_bor = por_s && !bor_s && state != rsq_pkg::ST_POR;
  wire trap_cf  = hard_trap_i && trap_active_i &&
                  hard_trap_level_i >= rsq_pkg::TRAP_HARD_MIN &&
                  hard_trap_level_i < trap_active_level_i;
  wire map_bad  = HAS_CM && !pin_map_we_i &&
                  pin_map_i != shadow;
  wire ill_op   = opcode_valid_i &&
                  opcode_upper_i == rsq_pkg::ILLEGAL_UPPER;
  assign warm.pin  = pin_low_f;
  assign warm.sw   = sw_reset_i;
  assign warm.wdt  = wdt_timeout_i && !sleep_mode_i;
  assign warm.trap = trap_cf;
  assign warm.cm   = map_bad;
  assign warm.ill  = ill_op || uninit_w_i || security_i;
  wire warm_any = |warm;

  wire [2:0] power_up_timer_sel = ctrl[rsq_pkg::CTRL_SEL_LSB +: 3];
  wire [31:0] power_up_timer_cyc = (power_up_timer_sel == 3'h0) ? 32'h0 :
    32'(POWER_UP_TIMER_UNIT_CYC) << power_up_timer_sel;

  // Reset sequence
  always_comb
  begin
    next_state = state;
    next_cnt   = 32'h0;
    if (cold_por)
      next_state = rsq_pkg::ST_POR;
    else if (cold_bor)
      next_state = rsq_pkg::ST_BOR;
    else
    begin
      case (state)
        rsq_pkg::ST_POR:
        begin
          next_cnt = cnt + 32'h1;
          if (cnt >= 32'(rsq_pkg::POR_EXT_CYC - 1))
          begin
            next_state = rsq_pkg::ST_BOR;
            next_cnt   = 32'h0;
          end
        end
        rsq_pkg::ST_BOR:
        begin
          next_cnt = cnt + 32'h1;
          if (cnt >= 32'(BOR_EXT_CYC - 1))
          begin
            next_state = rsq_pkg::ST_POWER_UP_TIMER;
            next_cnt   = 32'h0;
          end
        end
        rsq_pkg::ST_POWER_UP_TIMER:
        begin
          next_cnt = cnt + 32'h1;
          if (cnt >= power_up_timer_cyc)
          begin
            next_state = rsq_pkg::ST_OSC;
            next_cnt   = 32'h0;
          end
        end
        rsq_pkg::ST_OSC:
          if (osc_s)
            next_state = rsq_pkg::ST_RUN;
        rsq_pkg::ST_RUN:
          if (warm_any)
            next_state = rsq_pkg::ST_WARM;
        rsq_pkg::ST_WARM:
          if (!warm_any)
            next_state = rsq_pkg::ST_RUN;
        default:
          next_state = rsq_pkg::ST_POR;
      endcase
    end
  end

  wire run_next = next_state == rsq_pkg::ST_RUN;
  wire mon_en   = ctrl[rsq_pkg::CTRL_MON_EN];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state          <= rsq_pkg::ST_POR;
      cnt            <= 32'h0;
      system_reset_o <= 1'b1;
      fetch_start_o  <= 1'b0;
      fetch_addr_o   <= rsq_pkg::RESET_VECTOR;
      wake_o         <= 1'b0;
    end
    else if (ce_i)
    begin
      state          <= next_state;
      cnt            <= next_cnt;
      system_reset_o <= !(run_next ||
                          next_state == rsq_pkg::ST_OSC);
      fetch_start_o  <= run_next && state != rsq_pkg::ST_RUN;
      if (run_next && state != rsq_pkg::ST_RUN)
        fetch_addr_o <= rsq_pkg::RESET_VECTOR;
      else if (fetch_start_o)
        fetch_addr_o <= fetch_addr_o + 24'h000002;
      wake_o <= wdt_timeout_i && sleep_mode_i;
    end
  end

  // Oscillator source and clock monitor
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_source_o  <= 3'h0;
      mon_cnt         <= 32'h0;
      clock_monitor_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state == rsq_pkg::ST_POWER_UP_TIMER)
        clock_source_o <= initial_oscillator_select_i;
      else if (state == rsq_pkg::ST_RUN)
        clock_source_o <= current_oscillator_select_i;
      if (state != rsq_pkg::ST_RUN || !mon_en)
      begin
        mon_cnt         <= 32'h0;
        clock_monitor_o <= 1'b0;
      end
      else if (mon_cnt >= 32'(CLKMON_CYC - 1))
        clock_monitor_o <= 1'b1;
      else
        mon_cnt <= mon_cnt + 32'h1;
    end
  end

  // Wishbone slave
  wire wb_acc  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_flag = wb_acc && wb_we_i && wb_adr_i == rsq_pkg::ADR_FLAGS;
  wire wr_ctrl = wb_acc && wb_we_i && wb_adr_i == rsq_pkg::ADR_CTRL;
  wire [15:0] wr_mask = wr_flag ?
    ({{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & rsq_pkg::FLAG_MASK) : 16'h0;
  wire [15:0] sw_flags = (flags & ~wr_mask) |
    (wb_dat_i[15:0] & wr_mask);
  wire [15:0] wdt_clr = wdt_clear_i ?
    (16'h0001 << rsq_pkg::FLG_WDT) : 16'h0;

  logic [15:0] hw_set;
  always_comb
  begin
    hw_set = 16'h0;
    hw_set[rsq_pkg::FLG_BOR]  = cold_bor;
    hw_set[rsq_pkg::FLG_PIN]  = warm.pin;
    hw_set[rsq_pkg::FLG_SW]   = warm.sw;
    hw_set[rsq_pkg::FLG_WDT]  = wdt_timeout_i;
    hw_set[rsq_pkg::FLG_TRAP] = warm.trap;
    hw_set[rsq_pkg::FLG_CM]   = warm.cm;
    hw_set[rsq_pkg::FLG_ILL]  = warm.ill;
  end

  assign next_flags = cold_por ? rsq_pkg::FLAG_POR_VAL :
    ((sw_flags & ~wdt_clr &
      (cold_bor ? rsq_pkg::FLAG_BOR_KEEP : 16'hffff)) | hw_set);

  wire [31:0] rd_data =
    (wb_adr_i == rsq_pkg::ADR_FLAGS) ? {16'h0, flags} :
    (wb_adr_i == rsq_pkg::ADR_CTRL)  ? {28'h0, ctrl} :
    (wb_adr_i == rsq_pkg::ADR_STAT)  ?
      {20'h0, clock_monitor_o, clock_source_o, 2'h0, state} : 32'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flags    <= rsq_pkg::FLAG_POR_VAL;
      ctrl     <= rsq_pkg::CTRL_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else if (ce_i)
    begin
      flags    <= next_flags;
      wb_ack_o <= wb_acc;
      wb_dat_o <= wb_acc ? rd_data : 32'h0;
      if (wr_ctrl && wb_sel_i[0])
        ctrl <= wb_dat_i[3:0];
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  por_hold_a: assert property (
    (ce_i && cold_por) |=> system_reset_o && state == rsq_pkg::ST_POR)
    else $error("reset not held below power-on threshold");
  por_flag_a: assert property (
    (ce_i && cold_por) |=> flags[rsq_pkg::FLG_POR] &&
      flags[rsq_pkg::FLG_BOR])
    else $error("power-on flag not set");
  bor_flag_a: assert property (
    (ce_i && cold_bor) |=> flags[rsq_pkg::FLG_BOR] && system_reset_o)
    else $error("brown-out flag or reset missing");
  power_up_timer_restart_a: assert property (
    (ce_i && por_s && !bor_s && state == rsq_pkg::ST_POWER_UP_TIMER)
      |=> state == rsq_pkg::ST_BOR && cnt == 32'h0)
    else $error("delay did not restart on brown-out");
  fetch_vec_a: assert property (
    $rose(fetch_start_o) |-> fetch_addr_o == rsq_pkg::RESET_VECTOR &&
      !system_reset_o)
    else $error("fetch not at reset vector");
  sw_reset_a: assert property (
    (ce_i && por_s && bor_s && state == rsq_pkg::ST_RUN && sw_reset_i)
      |=> system_reset_o && flags[rsq_pkg::FLG_SW])
    else $error("software reset not taken");
  wdt_sleep_a: assert property (
    (ce_i && wdt_timeout_i && sleep_mode_i) |=> wake_o)
    else $error("watchdog wake missing");
  trap_flag_a: assert property (
    (ce_i && por_s && bor_s && trap_cf) |=> flags[rsq_pkg::FLG_TRAP])
    else $error("trap flag not set");
  illegal_op_a: assert property (
    (ce_i && por_s && bor_s && ill_op) |=> flags[rsq_pkg::FLG_ILL])
    else $error("illegal opcode not flagged");
  clk_mon_a: assert property (
    clock_monitor_o |-> $past(state) == rsq_pkg::ST_RUN &&
      mon_cnt >= 32'(CLKMON_CYC - 1))
    else $error("clock monitor started early");

endmodule

// >>> tb/rsq_pin_drv.sv
module rsq_pin_drv (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output wire logic       pin_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  // Low pulse of the commanded length, high otherwise
  always @(posedge clk_i)
  begin
    if (go_i)
      cnt <= len_i;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end
  assign pin_n_o = (cnt == 8'h00);
endmodule

// >>> tb/test_system_reset_sequencer.sv
module test_system_reset_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 20;
  localparam int MC = 30;
  localparam int UC = 4;
  localparam int CE = int'(rsq_pkg::POR_EXT_CYC) + BC + (UC << 7) + 1;
  logic        clk_i, rst_i, cyc, stb, we, ack, pok, bok, osc, sw, wdt;
  logic        slp, ht, ta, pwe, opv, uni, sec, go, srst, fst, cmon, wake;
  logic        ce, wclr;
  logic [3:0]  adr, hl, al;
  logic [2:0]  isel, csel, csrc;
  logic [7:0]  opu, len;
  logic [15:0] pm, pwd;
  logic [23:0] fa;
  logic [31:0] dw, dr, q, r;
  wire         pin_n;
  int          seed, fail_count, n_tests, c;

  rsq_top #(.BOR_EXT_CYC(BC), .CLKMON_CYC(MC), .POWER_UP_TIMER_UNIT_CYC(UC),
    .PIN_FILT_CYC(4), .MAP_W(16), .HAS_CM(1'b1)) u_rsq_top (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .power_on_threshold_i(pok), .brown_out_threshold_i(bok),
    .external_reset_pin_n_i(pin_n), .osc_ready_i(osc), .sw_reset_i(sw),
    .wdt_timeout_i(wdt), .wdt_clear_i(wclr), .sleep_mode_i(slp),
    .hard_trap_i(ht), .hard_trap_level_i(hl), .trap_active_i(ta),
    .trap_active_level_i(al), .pin_map_i(pm), .pin_map_wdata_i(pwd),
    .pin_map_we_i(pwe), .opcode_valid_i(opv), .opcode_upper_i(opu),
    .uninit_w_i(uni), .security_i(sec), .initial_oscillator_select_i(isel),
    .current_oscillator_select_i(csel), .system_reset_o(srst),
    .fetch_start_o(fst), .fetch_addr_o(fa), .clock_source_o(csrc),
    .clock_monitor_o(cmon), .wake_o(wake));

  rsq_pin_drv u_rsq_pin_drv (.clk_i(clk_i), .go_i(go), .len_i(len),
    .pin_n_o(pin_n));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic int pw(input int s);
    return (s == 0) ? 0 : UC << s;
  endfunction

  function automatic logic [31:0] ef(input int k);
    case (k)
      0: ef = 32'h1 << rsq_pkg::FLG_SW;
      1, 8: ef = 32'h1 << rsq_pkg::FLG_WDT;
      2: ef = 32'h1 << rsq_pkg::FLG_TRAP;
      3: ef = 32'h1 << rsq_pkg::FLG_CM;
      4, 5, 6: ef = 32'h1 << rsq_pkg::FLG_ILL;
      7: ef = 32'h1 << rsq_pkg::FLG_PIN;
      default: ef = 32'h0;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk(n, 32'd2, "bus answer");
    @(posedge clk_i);
  endtask

  // Wait for an output to reach v; lim+1 means not seen within lim clocks
  task automatic wt(input int i, input logic v, input int lim,
                    output int n);
    logic s;
    n = 0;
    s = (i == 0) ? srst : (i == 1) ? fst : (i == 2) ? cmon : wake;
    while (s !== v && n <= lim)
    begin
      @(posedge clk_i);
      n++;
      s = (i == 0) ? srst : (i == 1) ? fst : (i == 2) ? cmon : wake;
    end
  endtask

  task automatic bo_cycle(input int s, input bit dip);
    wb(1'b1, rsq_pkg::ADR_CTRL, 32'h8 | 32'(s), q);
    bok <= 1'b0;
    wt(0, 1'b1, 6, c);
    chk(32'(c <= 6), 32'h1, "brown-out reset");
    bok <= 1'b1;
    if (dip)
    begin
      tick(30);
      bok <= 1'b0;
      tick(4);
      bok <= 1'b1;
    end
    wt(0, 1'b0, 900, c);
    chk(32'(c >= BC + pw(s) + 1 && c <= BC + pw(s) + 7), 32'h1, "span");
    wt(1, 1'b1, 6, c);
    wt(2, 1'b1, 60, c);
    chk(32'(c >= MC - 3 && c <= MC + 3), 32'h1, "monitor");
    wb(1'b0, rsq_pkg::ADR_FLAGS, 32'h0, q);
    chk(q, 32'(rsq_pkg::FLAG_MASK & rsq_pkg::FLAG_BOR_KEEP), "bor flags");
  endtask

  task automatic pulse(input int k);
    r = $random(seed);
    case (k)
      0: sw <= 1'b1;
      1: wdt <= 1'b1;
      2, 9:
      begin
        ht <= 1'b1;
        ta <= 1'b1;
        hl <= (k == 2) ? (r[0] ? 4'he : 4'hd) : 4'hf;
        al <= (k == 2) ? 4'hf : 4'hd;
      end
      3: pm <= pm ^ 16'h0001;
      4, 10:
      begin
        opv <= 1'b1;
        opu <= (k == 4 || r[7:0] == 8'h3f) ? 8'h3f ^ {7'h0, k[3]} : r[7:0];
      end
      5: uni <= 1'b1;
      6: sec <= 1'b1;
      7, 11:
      begin
        go <= 1'b1;
        len <= (k == 7) ? 8'h0a : 8'h02;
      end
      default:
      begin
        slp <= 1'b1;
        wdt <= 1'b1;
      end
    endcase
    @(posedge clk_i);
    {sw, wdt, ht, ta, opv, uni, sec, go, slp} <= 9'h0;
    if (k == 3)
      pm <= pm ^ 16'h0001;
  endtask

  initial
  begin
    seed = 51852;
    fail_count = 0;
    n_tests = 0;
    rst_i = 1'b1;
    {cyc, stb, we, pok, bok, osc, sw, wdt, slp, ht, ta} = 11'h0;
    {pwe, opv, uni, sec, go} = 5'h0;
    {adr, hl, al, isel, csel, opu, len} = 34'h0;
    ce = 1'b1;
    wclr = 1'b0;
    {pm, pwd, dw} = 64'h0;
    tick(3);
    rst_i <= 1'b0;
    r = $random(seed);
    pm <= r[15:0];
    pwd <= r[15:0];
    pwe <= 1'b1;
    isel <= r[18:16];
    csel <= ~r[18:16];
    tick(1);
    pwe <= 1'b0;
    wb(1'b0, rsq_pkg::ADR_FLAGS, 32'h0, q);
    chk(q, 32'(rsq_pkg::FLAG_POR_VAL), "reset flags");
    wb(1'b0, rsq_pkg::ADR_CTRL, 32'h0, q);
    chk(q, 32'(rsq_pkg::CTRL_RST), "reset ctrl");
    wb(1'b0, 4'hc, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    pok <= 1'b1;
    bok <= 1'b1;
    wt(0, 1'b0, CE + 50, c);
    chk(32'(c >= CE && c <= CE + 7), 32'h1, "cold span");
    chk({29'h0, csrc}, {29'h0, isel}, "cold clock");
    wt(1, 1'b1, 8, c);
    chk(c, 32'd9, "fetch before ready");
    osc <= 1'b1;
    wt(1, 1'b1, 6, c);
    chk({8'h0, fa}, 32'(rsq_pkg::RESET_VECTOR), "vector");
    tick(MC + 5);
    chk({31'h0, cmon}, 32'h0, "monitor off");
    wb(1'b0, rsq_pkg::ADR_STAT, 32'h0, q);
    r = {20'h0, 1'b0, csel, 2'h0, 6'(rsq_pkg::ST_RUN)};
    chk(q, r, "status");
    ce <= 1'b0;
    pulse(0);
    tick(3);
    chk({31'h0, srst}, 32'h0, "frozen");
    ce <= 1'b1;
    wb(1'b0, rsq_pkg::ADR_FLAGS, 32'h0, q);
    chk(q, 32'(rsq_pkg::FLAG_POR_VAL), "frozen flags");
    $display("cold start done");
    for (int s = 0; s < 8; s++)
    begin
      wb(1'b1, rsq_pkg::ADR_FLAGS, 32'hffff, q);
      tick(4);
      chk({31'h0, srst}, 32'h0, "flag write");
      wb(1'b0, rsq_pkg::ADR_FLAGS, 32'h0, q);
      chk(q, 32'(rsq_pkg::FLAG_MASK), "flag set");
      bo_cycle(s, s == 2);
      $display("brown-out with delay select %0d done", s);
    end
    for (int k = 0; k < 12; k++)
    begin
      wb(1'b1, rsq_pkg::ADR_FLAGS, 32'h0, q);
      r = $random(seed);
      csel <= r[2:0];
      tick(3);
      pulse(k);
      if (k < 8)
      begin
        wt(0, 1'b1, 12, c);
        chk(32'(c <= 12), 32'h1, "warm reset");
        wt(0, 1'b0, 20, c);
        if (k == 0)
          chk(c, 32'd1, "sw width");
        chk({29'h0, csrc}, {29'h0, csel}, "warm clock");
        wt(1, 1'b1, 4, c);
        chk(32'(c <= 4), 32'h1, "refetch");
      end
      else
      begin
        if (k == 8)
        begin
          wt(3, 1'b1, 4, c);
          chk(32'(c <= 4), 32'h1, "wake");
        end
        wt(0, 1'b1, 12, c);
        chk(c, 32'd13, "no reset");
      end
      wb(1'b0, rsq_pkg::ADR_FLAGS, 32'h0, q);
      chk(q, ef(k), "cause flag");
      if (k == 8)
      begin
        wclr <= 1'b1;
        tick(1);
        wclr <= 1'b0;
        wb(1'b0, rsq_pkg::ADR_FLAGS, 32'h0, q);
        chk(q, 32'h0, "watchdog flag clear");
      end
      $display("source %0d done", k);
    end
    test_done;
  end

  initial
  begin
    #400000;
    fail_count++;
    $display("CHECK FAILED at %0t: timeout", $time);
    test_done;
  end
endmodule
